// ### pkg/cmp_pair_pkg.sv
`default_nettype none
package cmp_pair_pkg;
  localparam logic [5:0] CMP1_UPPER_ADDR = 6'h1b;
  localparam logic [5:0] CMP1_LOWER_ADDR = 6'h1c;
  localparam logic [5:0] CMP2_UPPER_ADDR = 6'h1d;
  localparam logic [5:0] CMP2_LOWER_ADDR = 6'h1e;
  localparam int OFF_BIT = 15;
  localparam logic [15:0] UPPER_RESET = 16'h00ff;
  localparam logic [15:0] LOWER_RESET = 16'hffff;
  localparam logic [23:0] VALUE_RESET = 24'hffffff;
  localparam logic ACTIVE_OFF_RESET = 1'b0;
endpackage
`default_nettype wire

// ### pkg/cmp_load_if.sv
`timescale 1ns/1ps
`default_nettype none
interface cmp_load_if;
  logic load;
  logic [15:0] upper;
  logic [15:0] lower;
  logic match;
  modport ctrl (output load, output upper, output lower, input match);
  modport unit (input load, input upper, input lower, output match);
endinterface
`default_nettype wire

// ### hw/cmp_unit.sv
`timescale 1ns/1ps
`default_nettype none
module cmp_unit (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic [23:0] i_timer,
  cmp_load_if.unit bus
);
  logic [23:0] value_q;
  logic off_q;

  // 24 bits and the off bit move together on the lower-register write
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      value_q <= cmp_pair_pkg::VALUE_RESET;
      off_q <= cmp_pair_pkg::ACTIVE_OFF_RESET;
    end else if (bus.load) begin
      value_q <= {bus.upper[7:0], bus.lower};
      off_q <= bus.upper[cmp_pair_pkg::OFF_BIT];
    end
  end

  // a disabled comparator never matches
  assign bus.match = !off_q && (value_q == i_timer);

  chk_off_no_match: assert property (
    @(posedge i_clk) disable iff (i_srst)
    bus.load && bus.upper[cmp_pair_pkg::OFF_BIT] |=> off_q && !bus.match)
    else $error("off bit not applied");
  chk_load_value: assert property (
    @(posedge i_clk) disable iff (i_srst)
    bus.load |=> value_q == {$past(bus.upper[7:0]), $past(bus.lower)})
    else $error("compare value not loaded");
  chk_hold_value: assert property (
    @(posedge i_clk) disable iff (i_srst)
    !bus.load |=> $stable(value_q) && $stable(off_q))
    else $error("comparator changed without load");
endmodule
`default_nettype wire

// ### hw/event_timer_compare_pair.sv
`timescale 1ns/1ps
`default_nettype none
module event_timer_compare_pair (
  input wire logic I_CLOCK,
  input wire logic I_SRST,
  input wire logic [5:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [15:0] i_reg_wdata,
  input wire logic i_reg_rd,
  input wire logic i_status_rd,
  input wire logic [23:0] i_timer,
  input wire logic i_doze,
  output logic [15:0] o_reg_rdata,
  output logic o_first_match_flag,
  output logic o_doze_match_flag,
  output logic o_doze_exit
);
  // ****************************************
  // staged registers
  // ****************************************
  logic [15:0] one_upper_q;
  logic [15:0] one_lower_q;
  logic [15:0] two_upper_q;
  logic [15:0] two_lower_q;
  logic [15:0] rdata_d;
  logic wr_one_lower;
  logic wr_two_lower;
  logic [15:0] upper_wdata;

  cmp_load_if one_if ();
  cmp_load_if two_if ();

  assign wr_one_lower = i_reg_wr
    && i_reg_addr == cmp_pair_pkg::CMP1_LOWER_ADDR;
  assign wr_two_lower = i_reg_wr
    && i_reg_addr == cmp_pair_pkg::CMP2_LOWER_ADDR;

  // reserved bits 14-8 are not stored and read as zero
  assign upper_wdata = {i_reg_wdata[15], 7'h00, i_reg_wdata[7:0]};

  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      one_upper_q <= cmp_pair_pkg::UPPER_RESET;
      one_lower_q <= cmp_pair_pkg::LOWER_RESET;
      two_upper_q <= cmp_pair_pkg::UPPER_RESET;
      two_lower_q <= cmp_pair_pkg::LOWER_RESET;
    end else if (i_reg_wr) begin
      case (i_reg_addr)
        cmp_pair_pkg::CMP1_UPPER_ADDR: begin
          one_upper_q <= upper_wdata;
        end
        cmp_pair_pkg::CMP1_LOWER_ADDR: begin
          one_lower_q <= i_reg_wdata;
        end
        cmp_pair_pkg::CMP2_UPPER_ADDR: begin
          two_upper_q <= upper_wdata;
        end
        cmp_pair_pkg::CMP2_LOWER_ADDR: begin
          two_lower_q <= i_reg_wdata;
        end
        default: begin
        end
      endcase
    end
  end

  chk_upper_stage: assert property (
    @(posedge I_CLOCK) disable iff (I_SRST)
    i_reg_wr && i_reg_addr == cmp_pair_pkg::CMP1_UPPER_ADDR
    |=> one_upper_q[7:0] == $past(i_reg_wdata[7:0]))
    else $error("upper not staged");

  chk_second_stage: assert property (
    @(posedge I_CLOCK) disable iff (I_SRST)
    i_reg_wr && i_reg_addr == cmp_pair_pkg::CMP2_UPPER_ADDR
    |=> two_upper_q == {$past(i_reg_wdata[15]), 7'h00,
    $past(i_reg_wdata[7:0])})
    else $error("second upper not staged");

  chk_lower_stage: assert property (
    @(posedge I_CLOCK) disable iff (I_SRST)
    wr_one_lower |=> one_lower_q == $past(i_reg_wdata))
    else $error("lower not stored");

  // ****************************************
  // comparator loads
  // ****************************************
  // lower data taken from the write bus so the load sees it the same cycle
  assign one_if.load = wr_one_lower;
  assign one_if.upper = one_upper_q;
  assign one_if.lower = i_reg_wdata;
  assign two_if.load = wr_two_lower;
  assign two_if.upper = two_upper_q;
  assign two_if.lower = i_reg_wdata;

  cmp_unit u_one (
    .i_clk(I_CLOCK),
    .i_srst(I_SRST),
    .i_timer(i_timer),
    .bus(one_if.unit)
  );

  cmp_unit u_two (
    .i_clk(I_CLOCK),
    .i_srst(I_SRST),
    .i_timer(i_timer),
    .bus(two_if.unit)
  );

  // ****************************************
  // read-back
  // ****************************************
  always_comb begin
    case (i_reg_addr)
      cmp_pair_pkg::CMP1_UPPER_ADDR: rdata_d = one_upper_q;
      cmp_pair_pkg::CMP1_LOWER_ADDR: rdata_d = one_lower_q;
      cmp_pair_pkg::CMP2_UPPER_ADDR: rdata_d = two_upper_q;
      cmp_pair_pkg::CMP2_LOWER_ADDR: rdata_d = two_lower_q;
      default: rdata_d = 16'h0000;
    endcase
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      o_reg_rdata <= 16'h0000;
    end else if (i_reg_rd) begin
      o_reg_rdata <= rdata_d;
    end
  end

  chk_read_data: assert property (
    @(posedge I_CLOCK) disable iff (I_SRST)
    i_reg_rd && i_reg_addr == cmp_pair_pkg::CMP1_LOWER_ADDR
    |=> o_reg_rdata == $past(one_lower_q))
    else $error("read data not staged value");

  chk_rdata_hold: assert property (
    @(posedge I_CLOCK) disable iff (I_SRST)
    !i_reg_rd |=> $stable(o_reg_rdata))
    else $error("read data moved without read");

  // ****************************************
  // match flags
  // ****************************************
  // set wins over a status-read clear in the same cycle
  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      o_first_match_flag <= 1'b0;
    end else if (one_if.match) begin
      o_first_match_flag <= 1'b1;
    end else if (i_status_rd) begin
      o_first_match_flag <= 1'b0;
    end
  end

  chk_first_flag_set: assert property (
    @(posedge I_CLOCK) disable iff (I_SRST)
    one_if.match |=> o_first_match_flag)
    else $error("flag one missed");

  chk_status_clear: assert property (
    @(posedge I_CLOCK) disable iff (I_SRST)
    i_status_rd && !one_if.match |=> !o_first_match_flag)
    else $error("flag one not cleared");

  chk_flag_needs_match: assert property (
    @(posedge I_CLOCK) disable iff (I_SRST)
    !one_if.match && !o_first_match_flag |=> !o_first_match_flag)
    else $error("flag one rose without match");

  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      o_doze_match_flag <= 1'b0;
    end else if (two_if.match && i_doze) begin
      o_doze_match_flag <= 1'b1;
    end else if (i_status_rd) begin
      o_doze_match_flag <= 1'b0;
    end
  end

  chk_doze_flag_set: assert property (
    @(posedge I_CLOCK) disable iff (I_SRST)
    two_if.match && i_doze |=> o_doze_match_flag && o_doze_exit)
    else $error("doze match missed");

  chk_doze_clear: assert property (
    @(posedge I_CLOCK) disable iff (I_SRST)
    i_status_rd && !(two_if.match && i_doze) |=> !o_doze_match_flag)
    else $error("doze flag not cleared");

  chk_no_doze_flag: assert property (
    @(posedge I_CLOCK) disable iff (I_SRST)
    !i_doze && !o_doze_match_flag |=> !o_doze_match_flag)
    else $error("doze flag outside doze");

  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      o_doze_exit <= 1'b0;
    end else begin
      o_doze_exit <= two_if.match && i_doze;
    end
  end

  chk_exit_pulse: assert property (
    @(posedge I_CLOCK) disable iff (I_SRST)
    !(two_if.match && i_doze) |=> !o_doze_exit)
    else $error("doze exit without match");
endmodule
`default_nettype wire

// ### dv/cmp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module cmp_host_model (
  input wire logic i_clk,
  input wire logic [15:0] i_rdata,
  output logic [5:0] o_addr = 6'h00,
  output logic o_wr = 1'b0,
  output logic o_rd = 1'b0,
  output logic [15:0] o_wdata = 16'h0000
);
  // ****
  // register access as the host drives it
  // ****
  task automatic put(input logic [5:0] a, input logic [15:0] d);
    o_addr = a;
    o_wdata = d;
    o_wr = 1'b1;
    @(posedge i_clk);
    #1;
  endtask
  // released data shows a changed value, never the last one
  task automatic release_wr;
    o_wr = 1'b0;
    o_wdata = ~o_wdata;
  endtask
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    put(a, d);
    release_wr();
  endtask
  task automatic pair(input logic [5:0] a, input logic [15:0] u, l);
    put(a, u);
    put(a + 6'h01, l);
    release_wr();
  endtask
  task automatic rd(input logic [5:0] a, output logic [15:0] d);
    o_addr = a;
    o_rd = 1'b1;
    @(posedge i_clk);
    #1 o_rd = 1'b0;
    @(posedge i_clk);
    #1 d = i_rdata;
  endtask
endmodule
`default_nettype wire

// ### dv/event_timer_compare_pair_tb.sv
`timescale 1ns/1ps
`default_nettype none
module event_timer_compare_pair_tb;
  // ****
  // stimulus and judging
  // ****
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic status_rd = 1'b0;
  logic doze = 1'b0;
  logic [23:0] timer = 24'h000000;
  logic [5:0] addr;
  logic wr, rd, f1, f2, dx;
  logic [15:0] wdata, rdata, q;
  int failures = 0;
  int n_checks = 0;
  cmp_host_model i_cmp_host_model (.i_clk(clk), .i_rdata(rdata),
    .o_addr(addr), .o_wr(wr), .o_rd(rd), .o_wdata(wdata));
  event_timer_compare_pair i_event_timer_compare_pair (.I_CLOCK(clk),
    .I_SRST(srst), .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_wdata(wdata),
    .i_reg_rd(rd), .i_status_rd(status_rd), .i_timer(timer), .i_doze(doze),
    .o_reg_rdata(rdata), .o_first_match_flag(f1), .o_doze_match_flag(f2),
    .o_doze_exit(dx));
  task automatic check(input string nm, input logic [23:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic final_report;
    if (failures == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic settle(input logic [23:0] t);
    timer = t;
    repeat (2) @(posedge clk);
    #1;
  endtask
  // a match beats a clear, so the timer is moved off first
  task automatic clear_flags;
    timer = 24'h000000;
    status_rd = 1'b1;
    @(posedge clk);
    #1 status_rd = 1'b0;
  endtask
  task automatic t_reset_vals;
    for (int a = 'h1b; a <= 'h1e; a++) begin
      i_cmp_host_model.rd(6'(a), q);
      check("reset read", q, a[0] ? 16'h00ff : 16'hffff);
    end
    i_cmp_host_model.rd(6'h1f, q);
    check("unmapped read", q, 16'h0000);
  endtask
  task automatic t_stage_load;
    settle(24'hffffff);
    check("reset compare", f1, 1'b1);
    check("doze flag awake", f2, 1'b0);
    clear_flags();
    check("cleared", f1, 1'b0);
    i_cmp_host_model.wr(6'h1b, 16'h0012);
    settle(24'h123456);
    check("staged only", f1, 1'b0);
    i_cmp_host_model.wr(6'h1c, 16'h3456);
    settle(24'h123456);
    check("lone lower load", f1, 1'b1);
    // timer still matches, so the set must win over the clear
    status_rd = 1'b1;
    @(posedge clk);
    #1 status_rd = 1'b0;
    check("set beats clear", f1, 1'b1);
    i_cmp_host_model.rd(6'h1c, q);
    check("lower readback", q, 16'h3456);
  endtask
  task automatic t_disable;
    clear_flags();
    i_cmp_host_model.wr(6'h1b, 16'h8012);
    settle(24'h123456);
    check("off staged", f1, 1'b1);
    clear_flags();
    i_cmp_host_model.pair(6'h1b, 16'h8012, 16'h3456);
    settle(24'h123456);
    check("disabled", f1, 1'b0);
    i_cmp_host_model.rd(6'h1b, q);
    check("upper readback", q, 16'h8012);
  endtask
  task automatic t_doze;
    i_cmp_host_model.wr(6'h1d, 16'h7f01);
    doze = 1'b1;
    settle(24'h010002);
    check("second staged", f2, 1'b0);
    doze = 1'b0;
    i_cmp_host_model.wr(6'h1e, 16'h0002);
    settle(24'h010002);
    check("no doze no flag", f2, 1'b0);
    doze = 1'b1;
    @(posedge clk);
    #1 check("doze flag", f2, 1'b1);
    check("doze exit", dx, 1'b1);
    timer = 24'h000000;
    doze = 1'b0;
    @(posedge clk);
    #1 check("exit pulse ends", dx, 1'b0);
    i_cmp_host_model.rd(6'h1d, q);
    check("second upper", q, 16'h0001);
    clear_flags();
    check("doze flag cleared", f2, 1'b0);
    i_cmp_host_model.wr(6'h1d, 16'h8001);
    doze = 1'b1;
    settle(24'h010002);
    check("second off staged", f2, 1'b1);
    clear_flags();
    i_cmp_host_model.wr(6'h1e, 16'h0002);
    settle(24'h010002);
    check("second disabled", f2, 1'b0);
    doze = 1'b0;
  endtask
  initial begin
    forever #5 clk = ~clk;
  end
  initial begin
    #100000;
    failures++;
    final_report();
  end
  initial begin
    repeat (2) @(posedge clk);
    #1 srst = 1'b0;
    t_reset_vals();
    t_stage_load();
    t_disable();
    t_doze();
    final_report();
  end
endmodule
`default_nettype wire
